//--- mac_defines.svh
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH

// =====================================================================
// register map (printed offsets are indices, byte address is index*4)
// =====================================================================
`define MAC_IDX_BANK_SEL 8'h9f
`define MAC_IDX_CTRL 8'hc7
`define MAC_ADDR_BANK_SEL 12'h27c
`define MAC_ADDR_CTRL 12'h31c
`define MAC_APB_AW 12

// =====================================================================
// control register fields
// =====================================================================
`define MAC_CTRL_UNIF 6
`define MAC_CTRL_BANK_HI 5
`define MAC_CTRL_BANK_LO 4
`define MAC_CTRL_CACHE_OFF 1
`define MAC_CTRL_RSVD 0
`define MAC_BANKSEL_HI 1
`define MAC_BANKSEL_LO 0

// =====================================================================
// reset values and fixed mapping
// =====================================================================
`define MAC_RST_UNIF 1'b0
`define MAC_RST_BANK 2'h1
`define MAC_RST_CACHE_OFF 1'b0
`define MAC_RST_RSVD 1'b1
`define MAC_FIXED_BANK 2'h1
`define MAC_CODE_UPPER 15
`define MAC_RAM_BASE_DEF 16'he000

`endif

//--- mac_pkg.sv
// =====================================================================
// shared types of the memory arbiter
// =====================================================================
package mac_pkg;
    // access sequencer states
    typedef enum logic [1:0] {
        MAC_IDLE = 2'b00,
        MAC_ACCESS = 2'b01,
        MAC_DONE = 2'b10
    } mac_state_t;
    // who owns the memory port
    typedef enum logic {
        MAC_OWNER_CPU = 1'b0,
        MAC_OWNER_DMA = 1'b1
    } mac_owner_t;
endpackage

//--- mac_arbiter.sv
// Operation
// R01: serve every cpu and dma memory access
// R02: unified bit maps ram into code space
// R03: software enables unified before running ram
// R04: bank select picks 32 KB upper code bank
// R05: bank select only effective on large flash
// R06: bank field shared by both registers
// R07: cache off invalidates, fetches bypass cache (code bypasses flash fetches only, ram fetches keep mem_bypass_cache low)
// R08: software keeps reserved control bit 0 set
// R09: dma wins same-cycle conflict, cpu stalls
`include "mac_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module mac_arbiter
    import mac_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b1,
    parameter logic [15:0] RAM_BASE = `MAC_RAM_BASE_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MAC_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor requester
    input wire logic cpu_req,
    input wire logic cpu_code,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ack,
    // dma requester
    input wire logic dma_req,
    input wire logic dma_we,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0] dma_wdata,
    output logic dma_ack,
    // shared read data to both requesters
    output logic [7:0] req_rdata,
    // physical memory port
    output logic mem_strobe,
    output logic mem_ram,
    output logic mem_we,
    output logic [16:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_bypass_cache,
    input wire logic mem_ready,
    input wire logic [7:0] mem_rdata,
    // instruction cache control
    output logic cache_off,
    output logic cache_invalidate
);

    // =================================================================
    // elaboration checks
    // =================================================================
    // ram window must lie in the upper code half
    if (RAM_BASE[`MAC_CODE_UPPER] != 1'b1) begin : g_bad_ram_base
        $error("ram base must lie in the upper code half");
    end

    // =================================================================
    // register storage
    // =================================================================
    logic unif; // unified code mapping
    logic [1:0] bank; // single copy of the bank field
    logic rsvd0; // reserved control bit, plain storage
    logic apb_wr; // write commits this edge
    logic sel_ctrl; // address hits control register
    logic sel_bank; // address hits bank register
    logic [31:0] next_rdata; // read value for setup cycle

    assign sel_ctrl = (paddr == `MAC_ADDR_CTRL);
    assign sel_bank = (paddr == `MAC_ADDR_BANK_SEL);
    assign apb_wr = psel & penable & pready & pwrite;

    // read mux, both views show the same bank bits
    always_comb begin
        next_rdata = 32'h0;
        if (sel_ctrl) begin
            next_rdata[`MAC_CTRL_UNIF] = unif;
            next_rdata[`MAC_CTRL_BANK_HI:`MAC_CTRL_BANK_LO] = bank; // R06
            next_rdata[`MAC_CTRL_CACHE_OFF] = cache_off;
            next_rdata[`MAC_CTRL_RSVD] = rsvd0;
        end else if (sel_bank) begin
            next_rdata[`MAC_BANKSEL_HI:`MAC_BANKSEL_LO] = bank; // R06
        end
    end

    // apb answer: zero wait states, captured in setup cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            // error stands only beside pready, never lingers into idle
            pslverr <= psel & ~penable & ~pready & ~(sel_ctrl | sel_bank);
            if (psel & ~penable) begin
                prdata <= next_rdata;
            end
        end
    end

    // control bits written via the control register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unif <= `MAC_RST_UNIF;
            cache_off <= `MAC_RST_CACHE_OFF;
            rsvd0 <= `MAC_RST_RSVD;
        end else if (apb_wr && sel_ctrl) begin
            unif <= pwdata[`MAC_CTRL_UNIF]; // R02
            cache_off <= pwdata[`MAC_CTRL_CACHE_OFF]; // R07
            rsvd0 <= pwdata[`MAC_CTRL_RSVD];
        end
    end

    // bank field, written through either location
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bank <= `MAC_RST_BANK;
        end else if (apb_wr && sel_ctrl) begin
            bank <= pwdata[`MAC_CTRL_BANK_HI:`MAC_CTRL_BANK_LO]; // R06
        end else if (apb_wr && sel_bank) begin
            bank <= pwdata[`MAC_BANKSEL_HI:`MAC_BANKSEL_LO]; // R06
        end
    end

    // one-cycle invalidate when the cache is switched off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cache_invalidate <= 1'b0;
        end else begin
            cache_invalidate <= apb_wr & sel_ctrl & ~cache_off
                & pwdata[`MAC_CTRL_CACHE_OFF]; // R07
        end
    end

    // =================================================================
    // address mapping
    // =================================================================
    mac_owner_t next_owner; // requester chosen this cycle
    logic pick_code; // chosen access is a code fetch
    logic [15:0] pick_addr; // chosen logical address
    logic next_ram; // chosen access lands in ram
    logic [16:0] next_maddr; // physical address
    logic [1:0] eff_bank; // bank that really applies
    logic [15:0] ram_off; // offset into ram window

    // dma first on any simultaneous request
    assign next_owner = dma_req ? MAC_OWNER_DMA : MAC_OWNER_CPU; // R09
    assign pick_code = (next_owner == MAC_OWNER_CPU) & cpu_code;
    assign pick_addr = (next_owner == MAC_OWNER_DMA) ? dma_addr : cpu_addr;
    // small flash: upper half is fixed, bank bits ignored
    assign eff_bank = LARGE_FLASH ? bank : `MAC_FIXED_BANK; // R05
    assign ram_off = pick_addr - RAM_BASE;

    // decode logical address into memory and physical address
    always_comb begin
        next_ram = 1'b0;
        next_maddr = {1'b0, pick_addr};
        if (pick_addr >= RAM_BASE && (!pick_code || unif)) begin
            // data space always sees ram, code only when unified
            next_ram = 1'b1; // R02
            next_maddr = {1'b0, ram_off};
        end else if (pick_code && pick_addr[`MAC_CODE_UPPER]) begin
            // upper code half through the bank window
            next_maddr = {eff_bank, pick_addr[`MAC_CODE_UPPER-1:0]}; // R04
        end
    end

    // =================================================================
    // access sequencer
    // =================================================================
    mac_state_t state; // sequencer state
    mac_owner_t owner; // requester being served

    // issue, wait for memory, acknowledge, then take next request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= MAC_IDLE;
            owner <= MAC_OWNER_CPU;
            mem_strobe <= 1'b0;
            mem_ram <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 17'h0;
            mem_wdata <= 8'h0;
            mem_bypass_cache <= 1'b0;
            cpu_ack <= 1'b0;
            dma_ack <= 1'b0;
            req_rdata <= 8'h0;
        end else begin
            cpu_ack <= 1'b0;
            dma_ack <= 1'b0;
            case (state)
                MAC_IDLE: begin
                    // any pending request is granted
                    if (cpu_req | dma_req) begin // R01
                        owner <= next_owner;
                        mem_strobe <= 1'b1;
                        mem_ram <= next_ram;
                        mem_addr <= next_maddr;
                        mem_we <= dma_req ? dma_we : cpu_we;
                        mem_wdata <= dma_req ? dma_wdata : cpu_wdata;
                        // flash fetches skip the cache while it is off, ram fetches never do
                        mem_bypass_cache <= pick_code & cache_off & ~next_ram; // R07
                        state <= MAC_ACCESS;
                    end
                end
                MAC_ACCESS: begin
                    // loser stays stalled until this completes
                    if (mem_ready) begin // R09
                        mem_strobe <= 1'b0;
                        req_rdata <= mem_rdata;
                        cpu_ack <= (owner == MAC_OWNER_CPU);
                        dma_ack <= (owner == MAC_OWNER_DMA);
                        state <= MAC_DONE;
                    end
                end
                MAC_DONE: begin
                    // requester drops or renews its request here
                    state <= MAC_IDLE;
                end
                default: begin
                    state <= MAC_IDLE;
                end
            endcase
        end
    end

endmodule // mac_arbiter

`default_nettype wire

//--- mac_arbiter_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module mac_arbiter_checker (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // requesters and memory
    input wire logic cpu_ack,
    input wire logic dma_ack,
    input wire logic mem_strobe,
    input wire logic mem_ready,
    input wire logic [16:0] mem_addr,
    input wire logic mem_bypass_cache,
    // cache
    input wire logic cache_off,
    input wire logic cache_invalidate
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no ready");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("long ready");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("lone error");
    a_ack_needs_ready: assert property ((cpu_ack || dma_ack) |-> $past(mem_strobe && mem_ready))
        else $error("early ack");
    a_strobe_then_ack: assert property (mem_strobe && mem_ready |=> !mem_strobe && (cpu_ack || dma_ack))
        else $error("no ack");
    a_single_winner: assert property (!(cpu_ack && dma_ack))
        else $error("two acks");
    a_addr_held: assert property (mem_strobe && !$rose(mem_strobe) |-> $stable(mem_addr))
        else $error("addr moved");
    a_bypass_cache_off: assert property (mem_strobe && mem_bypass_cache |-> cache_off)
        else $error("bad bypass");
    a_invalidate_on_off: assert property ($rose(cache_off) |-> ##[0:1] cache_invalidate)
        else $error("no invalidate");
endmodule // mac_arbiter_checker
`default_nettype wire

//--- mac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// memory behind the arbiter, answers after wait_cycles+1
module mac_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // memory port
    input wire logic mem_strobe,
    input wire logic mem_ram,
    input wire logic mem_bypass_cache,
    input wire logic [16:0] mem_addr,
    input wire logic [1:0] wait_cycles,
    output logic mem_ready,
    output logic [7:0] mem_rdata
);
    logic [1:0] cnt; // wait counter
    logic [7:0] cyc; // idle data pattern
    // ready after the chosen wait, dropped once seen
    always_ff @(posedge clk) begin
        cyc <= sys_rst ? 8'h00 : cyc + 8'h01;
        if (sys_rst || !mem_strobe || mem_ready) begin
            cnt <= 2'h0;
            mem_ready <= 1'b0;
        end else if (cnt == wait_cycles) begin
            mem_ready <= 1'b1;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    // data encodes address, target and bypass; changes every cycle when idle
    assign mem_rdata = mem_ready ? (mem_addr[7:0] ^ mem_addr[15:8]
        ^ {mem_ram, 5'h00, mem_bypass_cache, mem_addr[16]}) : cyc;
endmodule // mac_mem_model
`default_nettype wire

//--- test_memory_arbiter_code_mapping.sv
`include "mac_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module test_memory_arbiter_code_mapping;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, perr, cpu_req = 0, cpu_code = 0, dma_req = 0;
    logic [15:0] cpu_addr = 0, dma_addr = 0;
    logic cpu_ack, dma_ack, mem_strobe, mem_ram, mem_bypass_cache, mem_ready;
    logic cache_off, cache_invalidate, inv_seen = 0;
    logic [7:0] req_rdata, mem_rdata, d, e;
    logic [16:0] mem_addr, sm_addr, sm_seen = 0;
    logic cpu_we = 0, dma_we = 0, mem_we, sm_strobe;
    logic [7:0] cpu_wdata = 0, dma_wdata = 0, mem_wdata;
    logic [8:0] wr_seen = 0;
    logic [1:0] wt = 0;
    int failures = 0, checked = 0;
    time ta[2];
    always #5 clk = ~clk;
    always @(posedge clk) if (cache_invalidate === 1'b1) inv_seen <= 1;
    // direction and write data of each completed memory access
    always @(posedge clk) if (mem_strobe === 1'b1 && mem_ready === 1'b1)
        wr_seen <= {mem_we, mem_wdata};
    // physical address issued by the small flash variant
    always @(posedge clk) if (sm_strobe === 1'b1) sm_seen <= sm_addr;
    mac_arbiter mac_arbiter_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cpu_req, .cpu_code, .cpu_we,
        .cpu_addr, .cpu_wdata, .cpu_ack, .dma_req, .dma_we, .dma_addr,
        .dma_wdata, .dma_ack, .req_rdata, .mem_strobe, .mem_ram, .mem_we,
        .mem_addr, .mem_wdata, .mem_bypass_cache, .mem_ready, .mem_rdata,
        .cache_off, .cache_invalidate);
    // small flash variant in lockstep, bank bits must have no effect
    mac_arbiter #(.LARGE_FLASH(1'b0)) mac_arbiter_small_inst (.clk, .sys_rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .cpu_req,
        .cpu_code, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ack(), .dma_req, .dma_we,
        .dma_addr, .dma_wdata, .dma_ack(), .req_rdata(), .mem_strobe(sm_strobe),
        .mem_ram(), .mem_we(), .mem_addr(sm_addr), .mem_wdata(), .mem_bypass_cache(),
        .mem_ready, .mem_rdata, .cache_off(), .cache_invalidate());
    mac_mem_model mac_mem_model_inst (.clk, .sys_rst, .mem_strobe, .mem_ram,
        .mem_bypass_cache, .mem_addr, .wait_cycles(wt), .mem_ready, .mem_rdata);
    function automatic logic [7:0] fx(input logic r, b, input logic [16:0] p);
        return p[7:0] ^ p[15:8] ^ {r, 5'h00, b, p[16]};
    endfunction
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, x);
        checked++;
        if (g !== x) begin
            failures++;
            $display("Error at %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic wt_for(ref logic s);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 60);
        if (s !== 1'b1) begin
            failures++;
            $display("Error at %0t got %h exp %h", $time, s, 1'b1);
            stop_test;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk) penable <= 1;
        wt_for(pready);
        rd = prdata; perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic acc(input bit dm, input logic c, input logic [15:0] a, output logic [7:0] r);
        @(posedge clk);
        if (dm) begin dma_req <= 1; dma_addr <= a; end
        else begin cpu_req <= 1; cpu_code <= c; cpu_addr <= a; end
        if (dm) wt_for(dma_ack); else wt_for(cpu_ack);
        r = req_rdata; ta[dm] = $time;
        if (dm) dma_req <= 0; else cpu_req <= 0;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 0;
        apb(0, `MAC_ADDR_CTRL, 0); chk(rd, 32'h11);
        apb(0, `MAC_ADDR_BANK_SEL, 0); chk(rd, 32'h1);
        apb(0, 12'h000, 0); chk({31'h0, perr}, 32'h1);
        chk(rd, 32'h0);
        apb(1, `MAC_ADDR_CTRL, 32'h21); apb(0, `MAC_ADDR_BANK_SEL, 0); chk(rd, 32'h2);
        apb(1, `MAC_ADDR_BANK_SEL, 32'h3); apb(0, `MAC_ADDR_CTRL, 0); chk(rd, 32'h31);
        $display("register test done");
        for (int b = 0; b < 4; b++) begin
            wt <= 2'(b);
            apb(1, `MAC_ADDR_BANK_SEL, 32'(b));
            acc(0, 1, 16'h8123, d); chk(32'(d), 32'(fx(0, 0, {2'(b), 15'h0123})));
            chk(32'(sm_seen), 32'h08123);
        end
        acc(1, 0, 16'h8123, d); chk(32'(d), 32'(fx(0, 0, 17'h08123)));
        acc(0, 1, 16'he010, d); chk(32'(d), 32'(fx(0, 0, 17'h1e010)));
        apb(1, `MAC_ADDR_CTRL, 32'h41);
        acc(0, 1, 16'he010, d); chk(32'(d), 32'(fx(1, 0, 17'h00010)));
        $display("mapping test done");
        chk(32'(inv_seen), 32'h0);
        apb(1, `MAC_ADDR_CTRL, 32'h43);
        repeat (2) @(posedge clk);
        chk({cache_off, inv_seen}, 32'h3);
        acc(0, 1, 16'h0040, d); chk(32'(d), 32'(fx(0, 1, 17'h00040)));
        acc(1, 0, 16'h0040, d); chk(32'(d), 32'(fx(0, 0, 17'h00040)));
        chk(32'(wr_seen), 32'h0);
        fork
            acc(0, 1, 16'h0100, d);
            acc(1, 0, 16'hf000, e);
        join
        chk(32'(ta[1] < ta[0]), 32'h1);
        chk({d, e}, {fx(0, 1, 17'h00100), fx(1, 0, 17'h01000)});
        cpu_we <= 1;
        cpu_wdata <= 8'h5a;
        acc(0, 0, 16'he020, d); chk(32'(wr_seen), 32'h15a);
        cpu_we <= 0;
        dma_we <= 1;
        dma_wdata <= 8'ha5;
        acc(1, 0, 16'h0200, d); chk(32'(wr_seen), 32'h1a5);
        dma_we <= 0;
        $display("cache and conflict test done");
        stop_test;
    end
endmodule // test_memory_arbiter_code_mapping
bind mac_arbiter mac_arbiter_checker mac_arbiter_checker_inst (.clk, .sys_rst, .psel,
    .penable, .pready, .pslverr, .cpu_ack, .dma_ack, .mem_strobe, .mem_ready,
    .mem_addr, .mem_bypass_cache, .cache_off, .cache_invalidate);
`default_nettype wire
